// ---- design/serial_status_pkg.sv ----
// Package with offsets, field positions, encodings and carriers for the channel status block.
package serial_status_pkg;

  // Bus widths.
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // Per-channel offsets, indexed by channel number.
  localparam logic [11:0] CMD_OFFSET    [4] = '{12'h100, 12'h180, 12'h200, 12'h280};
  localparam logic [11:0] STATUS_OFFSET [4] = '{12'h104, 12'h184, 12'h204, 12'h284};
  localparam logic [11:0] ICHAR_OFFSET  [4] = '{12'h14C, 12'h1CC, 12'h24C, 12'h2CC};
  localparam logic [11:0] CTRL_OFFSET   [4] = '{12'h15C, 12'h1DC, 12'h25C, 12'h2DC};

  // Reset values.
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
  localparam logic [7:0]  CTRL_RESET   = 8'h00;
  localparam logic [7:0]  ICHAR_RESET  = 8'h00;

  // Command register bit positions.
  localparam int CMD_RNR_BIT  = 0;
  localparam int CMD_RRES_BIT = 16;
  localparam int CMD_RFRD_BIT = 17;
  localparam int CMD_HUNT_BIT = 18;
  localparam int CMD_XRES_BIT = 24;

  // Status register bit positions.
  localparam int ST_ICHAR_BUSY  = 29;
  localparam int ST_CMD_BUSY    = 28;
  localparam int ST_FLOW_STOP   = 27;
  localparam int ST_CTS         = 24;
  localparam int ST_SYNC        = 23;
  localparam int ST_LOCAL_FIFO  = 22;
  localparam int ST_CD          = 21;
  localparam int ST_LINE_IDLE   = 20;
  localparam int ST_DPLL_UNLOCK = 19;
  localparam int ST_AWAIT_ACK   = 18;
  localparam int ST_LOCAL_NR    = 17;
  localparam int ST_REMOTE_NR   = 16;

  // Protocol engine selection.
  localparam logic [1:0] MODE_HDLC   = 2'h0;
  localparam logic [1:0] MODE_BISYNC = 2'h2;
  localparam logic [1:0] MODE_ASYNC  = 2'h3;

  // Command busy may last 2.5 link clock periods, kept here in half periods.
  localparam int CMD_BUSY_HALF_PERIODS = 5;
  localparam int CMD_BUSY_EDGES        = CMD_BUSY_HALF_PERIODS / 2;
  localparam logic [1:0] CMD_BUSY_LAST = 2'(CMD_BUSY_EDGES);

  // Line idle is reported once more than this many ones arrive in a row.
  localparam int IDLE_ONES = 7;
  localparam logic [3:0] IDLE_LIMIT = 4'(IDLE_ONES + 1);

  // Synchroniser lanes: receive clock, transmit clock, clear-to-send, carrier detect.
  localparam int SYNC_W    = 4;
  localparam int LANE_RXC  = 0;
  localparam int LANE_TXC  = 1;
  localparam int LANE_CTSN = 2;
  localparam int LANE_CD   = 3;

  // Channel control register, bit 0 is the low mode bit.
  typedef struct packed {
    logic       syncIrqEn;
    logic       txFromDpll;
    logic       dpllRx;
    logic       powerUp;
    logic       flowEn;
    logic       autoMode;
    logic [1:0] mode;
  } ctrl_s;

  // Events and levels from the protocol engines, on the system clock.
  typedef struct packed {
    logic icharDone;
    logic xoffSeen;
    logic xonSeen;
    logic syncFound;
    logic localFifoNotEmpty;
    logic rxBitValid;
    logic rxBit;
    logic dpllUnlocked;
    logic awaitingAck;
    logic remoteRnrSet;
    logic remoteRnrClear;
  } engine_ev_s;

  // Commands handed to the protocol engines, one-cycle pulses.
  typedef struct packed {
    logic txReset;
    logic rxReset;
    logic hunt;
    logic rxFlush;
  } cmd_pulse_s;

endpackage

// ---- design/sync_two_stage.sv ----
// Two flip-flop synchroniser for the pin-level inputs of the status block.
`timescale 1ns/10ps
module sync_two_stage
  import serial_status_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic [SYNC_W-1:0] async,
  output logic      [SYNC_W-1:0] synced
);

  logic [SYNC_W-1:0] meta_q;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      meta_q <= '0;
      synced <= '0;
    end else begin
      meta_q <= async;
      synced <= meta_q;
    end
  end

endmodule // sync_two_stage

// ---- design/serial_channel_status_reg.sv ----
// Status register and receiver-not-ready control for one serial channel.
`timescale 1ns/10ps
module serial_channel_status_reg
  import serial_status_pkg::*;
#(
  parameter int CH_IDX = 0
) (
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [DATA_W-1:0] rdata,
  input  wire logic              rxClkPin,
  input  wire logic              txClkPin,
  input  wire logic              ctsPin_n,
  input  wire logic              cdPin,
  input  wire engine_ev_s        engineEv,
  output cmd_pulse_s             cmdPulse,
  output logic      [7:0]        immediateChar,
  output logic                   immediateCharLoad,
  output logic                   localNotReady,
  output logic                   syncLocked,
  output logic                   syncDetectIrq,
  output logic                   rxAbort,
  output logic                   txHalt
);

  // True when the bus address matches the given offset.
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] offs);
    return a == offs;
  endfunction

  // True on a rising edge of a synchronised level, given its previous value.
  function automatic logic risingEdge(input logic now, input logic was);
    return now && !was;
  endfunction

  // Registered state.
  ctrl_s       ctrl_q;
  logic        rnrCmd_q;
  logic        icharBusy_q;
  logic        cmdBusy_q;
  logic        cmdOnTx_q;
  logic [1:0]  edgeCnt_q;
  logic        prevRxClk_q;
  logic        prevTxClk_q;
  logic        flowStop_q;
  logic        syncLock_q;
  logic [3:0]  onesCnt_q;
  logic        lineIdle_q;
  logic        remoteNr_q;

  // Combinational helpers.
  logic [SYNC_W-1:0] pins;
  logic        cmdWr;
  logic        icharWr;
  logic        ctrlWr;
  logic        anyCmd;
  logic        isHdlc;
  logic        isAsync;
  logic        isBisync;
  logic        autoHdlc;
  logic        linkEdge;
  logic        dpllUnlockValid;
  logic        ctsInactive;
  logic        txResetWr;
  logic        huntWr;
  logic        rxClkRise;
  logic        txClkRise;
  logic [31:0] statusWord;

  // Pins come from outside the clock domain and are synchronised first.
  sync_two_stage pinSync (
    .clk    (clk),
    .nrst   (nrst),
    .async  ({cdPin, ctsPin_n, txClkPin, rxClkPin}),
    .synced (pins)
  );

  // Address decode and mode qualifiers.
  assign cmdWr    = wr && hit(addr, CMD_OFFSET[CH_IDX]);
  assign icharWr  = wr && hit(addr, ICHAR_OFFSET[CH_IDX]);
  assign ctrlWr   = wr && hit(addr, CTRL_OFFSET[CH_IDX]);
  assign anyCmd   = wdata[CMD_XRES_BIT] || wdata[CMD_RRES_BIT]
                  || wdata[CMD_HUNT_BIT] || wdata[CMD_RFRD_BIT];
  assign isHdlc   = ctrl_q.mode == MODE_HDLC;
  assign isAsync  = ctrl_q.mode == MODE_ASYNC;
  assign isBisync = ctrl_q.mode == MODE_BISYNC;
  assign autoHdlc = isHdlc && ctrl_q.autoMode;
  assign ctsInactive = pins[LANE_CTSN];

  // Command strokes that several processes act on, decoded once so that the
  // pulse and the status flags agree on one write.
  assign txResetWr = cmdWr && wdata[CMD_XRES_BIT];
  assign huntWr    = cmdWr && wdata[CMD_HUNT_BIT] && isBisync;

  // The unlock flag only means something with a recovered, FM or Manchester coded clock.
  assign dpllUnlockValid = ctrl_q.dpllRx && engineEv.dpllUnlocked;

  // Rising edges of both link clocks after the synchroniser. The history flops
  // reset low, the level of a stopped clock, so reset makes no false edge.
  assign rxClkRise = risingEdge(pins[LANE_RXC], prevRxClk_q);
  assign txClkRise = risingEdge(pins[LANE_TXC], prevTxClk_q);

  // A rising edge of whichever link clock the pending command needs.
  assign linkEdge = cmdOnTx_q ? txClkRise : rxClkRise;

  // Channel control register, written by software.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctrl_q <= ctrl_s'(CTRL_RESET);
    end else if (ctrlWr) begin
      ctrl_q <= ctrl_s'(wdata[7:0]);
    end
  end

  // The not-ready bit keeps whatever was last written to the command register.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rnrCmd_q <= 1'b0;
    end else if (cmdWr) begin
      rnrCmd_q <= wdata[CMD_RNR_BIT];
    end
  end

  // Local receiver state only follows the bit in auto HDLC mode, so polls
  // and I-frames are answered ready or not ready from this flop.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      localNotReady <= 1'b0;
    end else begin
      localNotReady <= autoHdlc && rnrCmd_q;
    end
  end

  // Self-clearing commands leave as one-cycle pulses; hunt only in bisync, receive flush not in HDLC.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cmdPulse <= '0;
    end else begin
      cmdPulse.txReset <= txResetWr;
      cmdPulse.rxReset <= cmdWr && wdata[CMD_RRES_BIT];
      cmdPulse.hunt    <= huntWr;
      cmdPulse.rxFlush <= cmdWr && wdata[CMD_RFRD_BIT] && !isHdlc;
    end
  end

  // Link clock history for edge detection, taken from the second sync stage.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      prevRxClk_q <= 1'b0;
      prevTxClk_q <= 1'b0;
    end else begin
      prevRxClk_q <= pins[LANE_RXC];
      prevTxClk_q <= pins[LANE_TXC];
    end
  end

  // Command busy counts edges of the needed link clock. Counting two rising
  // edges keeps it inside 2.5 periods; with no edges, or powered down, it
  // simply never finishes. A write while busy is not refused, it restarts.
  // A transmitter reset waits on the transmit clock, every other command on
  // the receive clock, as the engine that carries it out runs on that clock.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cmdBusy_q <= 1'b0;
      cmdOnTx_q <= 1'b0;
      edgeCnt_q <= 2'h0;
    end else if (cmdWr && anyCmd) begin
      cmdBusy_q <= 1'b1;
      cmdOnTx_q <= wdata[CMD_XRES_BIT];
      edgeCnt_q <= 2'h0;
    end else if (cmdBusy_q && ctrl_q.powerUp && linkEdge) begin
      if (edgeCnt_q == CMD_BUSY_LAST - 2'h1) begin
        cmdBusy_q <= 1'b0;
        edgeCnt_q <= 2'h0;
      end else begin
        edgeCnt_q <= edgeCnt_q + 2'h1;
      end
    end
  end

  // Immediate character: a write in async mode sets busy and hands the byte over.
  // A write in the same cycle as completion wins, so the new one is kept.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      icharBusy_q       <= 1'b0;
      immediateChar     <= ICHAR_RESET;
      immediateCharLoad <= 1'b0;
    end else begin
      immediateCharLoad <= icharWr && isAsync;
      if (icharWr && isAsync) begin
        icharBusy_q   <= 1'b1;
        immediateChar <= wdata[7:0];
      end else if (engineEv.icharDone) begin
        icharBusy_q <= 1'b0;
      end
    end
  end

  // Flow stop: XOFF sets, XON or transmitter reset clears; XOFF wins a tie.
  // The state is kept when flow control is switched off, but then reads zero.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      flowStop_q <= 1'b0;
    end else if (isAsync && ctrl_q.flowEn && engineEv.xoffSeen) begin
      flowStop_q <= 1'b1;
    end else if (engineEv.xonSeen || txResetWr) begin
      flowStop_q <= 1'b0;
    end
  end

  // Sync lock: a hunt command drops it at once, a found sync sets it.
  // A sync arriving with the hunt belongs to the old search and is dropped.
  // The interrupt is one pulse, raised only on the step from unlocked to locked.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      syncLock_q    <= 1'b0;
      syncDetectIrq <= 1'b0;
    end else begin
      syncDetectIrq <= 1'b0;
      if (huntWr) begin
        syncLock_q <= 1'b0;
      end else if (isBisync && engineEv.syncFound && !syncLock_q) begin
        syncLock_q    <= 1'b1;
        syncDetectIrq <= ctrl_q.syncIrqEn;
      end
    end
  end

  // Receive data is forwarded while synchronised.
  assign syncLocked = syncLock_q;

  // Line idle: count ones in a row, saturate, and clear on any zero.
  // The counter stops at its limit so a long idle line cannot wrap it to zero.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      onesCnt_q  <= 4'h0;
      lineIdle_q <= 1'b0;
    end else if (engineEv.rxBitValid) begin
      if (!engineEv.rxBit) begin
        onesCnt_q  <= 4'h0;
        lineIdle_q <= 1'b0;
      end else if (onesCnt_q != IDLE_LIMIT) begin
        onesCnt_q  <= onesCnt_q + 4'h1;
        lineIdle_q <= (onesCnt_q + 4'h1) == IDLE_LIMIT;
      end
    end
  end

  // Remote not-ready follows the frames seen; a set beats a clear.
  // Losing a set would let this station send into a busy receiver.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      remoteNr_q <= 1'b0;
    end else if (engineEv.remoteRnrSet) begin
      remoteNr_q <= 1'b1;
    end else if (engineEv.remoteRnrClear) begin
      remoteNr_q <= 1'b0;
    end
  end

  // Loss of lock aborts reception and stops a DPLL-clocked transmitter the
  // same way an inactive clear-to-send does.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rxAbort <= 1'b0;
      txHalt  <= 1'b0;
    end else begin
      rxAbort <= dpllUnlockValid;
      txHalt  <= ctsInactive || (dpllUnlockValid && ctrl_q.txFromDpll);
    end
  end

  // Status word built live, each bit only in the modes that define it.
  // Pin mirrors, unlock and command busy are defined in every protocol mode.
  always_comb begin
    statusWord = STATUS_RESET;
    statusWord[ST_CMD_BUSY]    = cmdBusy_q;
    statusWord[ST_CTS]         = !pins[LANE_CTSN];
    statusWord[ST_CD]          = pins[LANE_CD];
    statusWord[ST_DPLL_UNLOCK] = dpllUnlockValid;
    // The local not-ready flop already folds in auto HDLC mode, so the bit
    // and the output pin never disagree, even in the cycle after a mode change.
    statusWord[ST_LOCAL_NR]    = localNotReady;
    // Bits that the active mode leaves undefined keep their zero.
    if (isAsync) begin
      statusWord[ST_ICHAR_BUSY] = icharBusy_q;
      statusWord[ST_FLOW_STOP]  = flowStop_q && ctrl_q.flowEn;
    end
    if (isAsync || isBisync) begin
      statusWord[ST_LOCAL_FIFO] = engineEv.localFifoNotEmpty;
    end
    if (isBisync) begin
      statusWord[ST_SYNC] = syncLock_q;
    end
    if (isHdlc) begin
      statusWord[ST_LINE_IDLE] = lineIdle_q;
    end
    if (autoHdlc) begin
      statusWord[ST_AWAIT_ACK]  = engineEv.awaitingAck;
      statusWord[ST_REMOTE_NR]  = remoteNr_q;
    end
  end

  // Read data stands for the one cycle after the strobe. Reads change no
  // state, and writes to the status offset are ignored.
  // Only the status and control offsets answer a read; all else reads zero.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdata <= STATUS_RESET;
    end else if (!rd) begin
      rdata <= '0;
    end else if (hit(addr, STATUS_OFFSET[CH_IDX])) begin
      rdata <= statusWord;
    end else if (hit(addr, CTRL_OFFSET[CH_IDX])) begin
      rdata <= {24'h00_0000, ctrl_q};
    end else begin
      rdata <= '0;
    end
  end

endmodule // serial_channel_status_reg

// ---- sim/remote_station_model.sv ----
// Far-side model that supplies the receive and transmit link clocks.
`timescale 1ns/10ps
module remote_station_model #(
  parameter int HALF = 4
) (
  input  wire logic clk,
  input  wire logic rxRun,
  input  wire logic txRun,
  output logic      rxClk,
  output logic      txClk
);
  int cnt;

  // Both clocks start low so the channel never sees a spurious first edge.
  initial begin
    cnt   = 0;
    rxClk = 1'b0;
    txClk = 1'b0;
  end

  // A stopped clock holds its level, which is how an absent clock looks to the channel.
  always @(posedge clk) begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1) begin
      if (rxRun) rxClk <= ~rxClk;
      if (txRun) txClk <= ~txClk;
    end
  end
endmodule // remote_station_model

// ---- sim/serial_status_asserts.sv ----
// Port-level checker for the channel status block.
`timescale 1ns/10ps
module serial_status_asserts
  import serial_status_pkg::*;
#(
  parameter int CH_IDX = 0
) (
  input wire logic              clk,
  input wire logic              nrst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic              wr,
  input wire logic              rd,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic              rxClkPin,
  input wire logic              txClkPin,
  input wire logic              ctsPin_n,
  input wire logic              cdPin,
  input wire engine_ev_s        engineEv,
  input wire cmd_pulse_s        cmdPulse,
  input wire logic [7:0]        immediateChar,
  input wire logic              immediateCharLoad,
  input wire logic              localNotReady,
  input wire logic              syncLocked,
  input wire logic              syncDetectIrq,
  input wire logic              rxAbort,
  input wire logic              txHalt
);
  localparam logic [11:0] STA = STATUS_OFFSET[CH_IDX];
  localparam logic [11:0] ICH = ICHAR_OFFSET[CH_IDX];
  logic [2:0] pinAge_q;
  logic       ctsLast_q;
  logic       cdLast_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // Pin age lets the pin checks wait out the synchroniser latency.
  always_ff @(posedge clk) begin
    ctsLast_q <= ctsPin_n;
    cdLast_q  <= cdPin;
    if (!nrst || ctsPin_n != ctsLast_q || cdPin != cdLast_q) begin
      pinAge_q <= 3'h0;
    end else if (pinAge_q != 3'h7) begin
      pinAge_q <= pinAge_q + 3'h1;
    end
  end

  AST_RDATA_IDLE: assert property (!$past(rd) |-> rdata == 32'h0000_0000)
    else $error("read data seen without a read");
  AST_LOW_ZERO: assert property ($past(rd) && $past(addr) == STA |-> rdata[15:0] == 16'h0000)
    else $error("unused status bits not zero");
  AST_CTS: assert property ($past(rd) && $past(addr) == STA && $past(pinAge_q) >= 3'h4
    |-> rdata[ST_CTS] == !$past(ctsPin_n, 3))
    else $error("clear-to-send status wrong");
  AST_CD: assert property ($past(rd) && $past(addr) == STA && $past(pinAge_q) >= 3'h4
    |-> rdata[ST_CD] == $past(cdPin, 3))
    else $error("carrier status wrong");
  AST_LOCAL_NR: assert property ($past(rd) && $past(addr) == STA
    |-> rdata[ST_LOCAL_NR] == $past(localNotReady))
    else $error("local not-ready status wrong");
  AST_HUNT: assert property (cmdPulse.hunt |-> !syncLocked)
    else $error("sync kept after hunt");
  AST_SYNC_IRQ: assert property (syncDetectIrq |-> syncLocked && !$past(syncLocked))
    else $error("sync interrupt without new lock");
  AST_ICHAR: assert property (immediateCharLoad |-> $past(wr) && $past(addr) == ICH
    && immediateChar == $past(wdata[7:0]))
    else $error("immediate character load wrong");
  AST_TX_HALT: assert property (ctsPin_n [*4] |=> txHalt)
    else $error("transmit not halted");
  AST_RX_ABORT: assert property (rxAbort |-> $past(engineEv.dpllUnlocked))
    else $error("receive abort without unlock");

  CV_HUNT: cover property (cmdPulse.hunt);
  CV_SYNC: cover property (syncDetectIrq);
  CV_DPLL: cover property (rxAbort && txHalt);
endmodule // serial_status_asserts

bind serial_channel_status_reg serial_status_asserts #(.CH_IDX(CH_IDX)) u_chk (
  .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .rxClkPin(rxClkPin), .txClkPin(txClkPin), .ctsPin_n(ctsPin_n), .cdPin(cdPin),
  .engineEv(engineEv), .cmdPulse(cmdPulse), .immediateChar(immediateChar),
  .immediateCharLoad(immediateCharLoad), .localNotReady(localNotReady),
  .syncLocked(syncLocked), .syncDetectIrq(syncDetectIrq), .rxAbort(rxAbort), .txHalt(txHalt)
);

// ---- sim/tb_serial_channel_status_reg.sv ----
// Self-checking bench for the status register of one serial channel.
`timescale 1ns/10ps
module tb_serial_channel_status_reg
  import serial_status_pkg::*;
;
  localparam int          HALF = 4;
  localparam int          LIM  = 5 * HALF + 4;
  localparam logic [11:0] STA  = STATUS_OFFSET[0];
  localparam logic [11:0] CMD  = CMD_OFFSET[0];
  localparam logic [11:0] ICH  = ICHAR_OFFSET[0];
  localparam logic [11:0] CTL  = CTRL_OFFSET[0];
  logic              clk = 1'b0;
  logic              nrst = 1'b0;
  logic              wr = 1'b0;
  logic              rd = 1'b0;
  logic              ctsPin_n = 1'b1;
  logic              cdPin = 1'b0;
  logic              rxRun = 1'b1;
  logic              txRun = 1'b1;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  engine_ev_s        ev = '0;
  logic [DATA_W-1:0] rdata;
  cmd_pulse_s        cmdPulse;
  logic [7:0]        immediateChar;
  logic              icLoad, localNotReady, syncLocked, syncDetectIrq, rxAbort, txHalt;
  logic              rxClk, txClk;
  int                bad_count = 0;
  int                checks = 0;
  int                cyc = 0;

  serial_channel_status_reg #(.CH_IDX(0)) u_dut (
    .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .rxClkPin(rxClk), .txClkPin(txClk), .ctsPin_n(ctsPin_n), .cdPin(cdPin), .engineEv(ev),
    .cmdPulse(cmdPulse), .immediateChar(immediateChar), .immediateCharLoad(icLoad),
    .localNotReady(localNotReady), .syncLocked(syncLocked), .syncDetectIrq(syncDetectIrq),
    .rxAbort(rxAbort), .txHalt(txHalt)
  );
  remote_station_model #(.HALF(HALF)) u_far (
    .clk(clk), .rxRun(rxRun), .txRun(txRun), .rxClk(rxClk), .txClk(txClk)
  );

  // System clock, 10 ns period.
  always #5 clk = ~clk;

  function automatic logic [31:0] bt(input int i);
    return 32'h1 << i;
  endfunction

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h, wanted %h", $time, got, exp);
    end
  endtask

  task automatic wr32(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample just after that edge.
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 cmp(rdata, exp);
  endtask

  task automatic evp(input int b);
    @(posedge clk);
    ev[b] <= 1'b1;
    @(posedge clk);
    ev[b] <= 1'b0;
  endtask

  task automatic sendbit(input logic v);
    @(posedge clk);
    ev.rxBit      <= v;
    ev.rxBitValid <= 1'b1;
    @(posedge clk);
    ev.rxBitValid <= 1'b0;
  endtask

  // Polls the busy flag; the bound covers 2.5 link periods plus synchroniser delay.
  task automatic waitidle();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      addr <= STA;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      n += 2;
      #1;
    end while (rdata[ST_CMD_BUSY] !== 1'b0 && n < 60);
    cmp(32'(n <= LIM), 32'h1);
  endtask

  task automatic done(input string s);
    $display("test %s done", s);
  endtask

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Guard against a hang; the whole sequence needs well under this many cycles.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      stop_test();
    end
  end

  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    rdchk(STA, 32'h0);
    rdchk(CTL, 32'h0);
    rdchk(12'h3FC, 32'h0);
    wr32(STA, 32'hFFFF_FFFF);
    rdchk(STA, 32'h0);
    done("reset");
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      ctsPin_n <= i[0];
      cdPin    <= i[1];
      repeat (4) @(posedge clk);
      rdchk(STA, (i[0] ? 32'h0 : bt(ST_CTS)) | (i[1] ? bt(ST_CD) : 32'h0));
    end
    @(posedge clk);
    cdPin <= 1'b0;
    repeat (4) @(posedge clk);
    done("pins");
    wr32(CMD, bt(CMD_RRES_BIT));
    #1 cmp({28'h000_0000, cmdPulse}, 32'h0000_0004);
    rdchk(STA, bt(ST_CMD_BUSY));
    repeat (40) @(posedge clk);
    rdchk(STA, bt(ST_CMD_BUSY));
    wr32(CTL, 32'h0000_0010);
    waitidle();
    @(posedge clk);
    txRun <= 1'b0;
    wr32(CMD, bt(CMD_XRES_BIT));
    #1 cmp({28'h000_0000, cmdPulse}, 32'h0000_0008);
    repeat (40) @(posedge clk);
    rdchk(STA, bt(ST_CMD_BUSY));
    @(posedge clk);
    txRun <= 1'b1;
    waitidle();
    rdchk(STA, 32'h0);
    done("busy");
    for (int k = 1; k <= IDLE_ONES + 1; k++) begin
      sendbit(1'b1);
      rdchk(STA, (k > IDLE_ONES) ? bt(ST_LINE_IDLE) : 32'h0);
    end
    sendbit(1'b0);
    rdchk(STA, 32'h0);
    done("idle");
    wr32(CTL, 32'h0000_0014);
    wr32(CMD, 32'h1);
    repeat (20) @(posedge clk);
    #1 cmp(32'(localNotReady), 32'h1);
    rdchk(STA, bt(ST_LOCAL_NR));
    evp(1);
    @(posedge clk);
    ev.awaitingAck <= 1'b1;
    rdchk(STA, bt(ST_LOCAL_NR) | bt(ST_REMOTE_NR) | bt(ST_AWAIT_ACK));
    @(posedge clk);
    ev.awaitingAck <= 1'b0;
    evp(0);
    wr32(CMD, 32'h0);
    rdchk(STA, 32'h0);
    cmp(32'(localNotReady), 32'h0);
    wr32(CMD, 32'h1);
    wr32(CTL, 32'h0000_0010);
    rdchk(STA, 32'h0);
    cmp(32'(localNotReady), 32'h0);
    done("auto");
    wr32(CTL, 32'h0000_001B);
    wr32(ICH, 32'h0000_005A);
    #1 cmp({23'h0, icLoad, immediateChar}, 32'h0000_015A);
    rdchk(STA, bt(ST_ICHAR_BUSY));
    evp(10);
    rdchk(STA, 32'h0);
    evp(9);
    rdchk(STA, bt(ST_FLOW_STOP));
    evp(8);
    rdchk(STA, 32'h0);
    evp(9);
    wr32(CMD, bt(CMD_XRES_BIT));
    #1 cmp({28'h000_0000, cmdPulse}, 32'h0000_0008);
    rdchk(STA, bt(ST_CMD_BUSY));
    waitidle();
    wr32(CMD, bt(CMD_RFRD_BIT));
    #1 cmp({28'h000_0000, cmdPulse}, 32'h0000_0001);
    waitidle();
    @(posedge clk);
    ev.localFifoNotEmpty <= 1'b1;
    rdchk(STA, bt(ST_LOCAL_FIFO));
    @(posedge clk);
    ev.localFifoNotEmpty <= 1'b0;
    done("async");
    wr32(CTL, 32'h0000_0092);
    evp(7);
    #1 cmp(32'(syncDetectIrq), 32'h1);
    rdchk(STA, bt(ST_SYNC));
    wr32(CMD, bt(CMD_HUNT_BIT));
    #1 cmp({28'h000_0000, cmdPulse}, 32'h0000_0002);
    rdchk(STA, bt(ST_CMD_BUSY));
    waitidle();
    done("bisync");
    wr32(CTL, 32'h0000_0070);
    ctsPin_n <= 1'b0;
    repeat (4) @(posedge clk);
    #1 cmp(32'(txHalt), 32'h0);
    @(posedge clk);
    ev.dpllUnlocked <= 1'b1;
    repeat (3) @(posedge clk);
    #1 cmp({30'h0, rxAbort, txHalt}, 32'h3);
    rdchk(STA, bt(ST_DPLL_UNLOCK) | bt(ST_CTS));
    done("dpll");
    stop_test();
  end
endmodule // tb_serial_channel_status_reg
